// [verilog/synth_retune_control_regs.sv]
// How it works
// - Fraction is 24 bits over high, middle and low byte registers.
// - Fraction bytes are read/write and loaded from the default store.
// - Control register answers at two aliased addresses, one storage.
// - Override bit 7 set forces the output buffer on.
// - Override clear: enable pin polarity decides, open pin means enabled.
// - Bit 2 copies user settings to working registers and retunes.
// - Bit 2 clears only after retune and calibration both finish.
// - Bit 1 copies settings and retunes without calibration.
// - Bit 1 clears once the small-step change completes.
// - Bit 0 reloads user registers from store, then clears.
// - Reload alone leaves working registers and frequency untouched.
// - Writing 0x05 performs reload followed by calibrated retune.
// - Calibrated retune stops the output clock until calibration ends.
// - Small-step change keeps the clock running; small moves only.
// - Small-step transfers integer and fraction only, not output divider.
`timescale 1ns/1ps
`default_nettype none
`include "srcr_regs.svh"

module synth_retune_control_regs
  import srcr_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire srcr_reg_req_s           reg_req_in,
  output logic [7:0]                   reg_rdata_out,
  input  wire logic                    oe_pin_in,
  input  wire logic                    oe_active_low_in,
  input  wire logic [`SRCR_INT_W-1:0]  user_integer_in,
  input  wire logic [`SRCR_OUTPUT_DIVIDER_RATIO_W-1:0] user_output_divider_ratio_in,
  input  wire logic [`SRCR_FRAC_W-1:0] nvm_fraction_in,
  input  wire logic                    nvm_done_in,
  input  wire logic                    cal_done_in,
  input  wire logic                    fine_done_in,
  output logic                         nvm_reload_req_out,
  output logic                         cal_start_out,
  output logic                         fine_start_out,
  output logic                         clock_run_out,
  output logic                         output_enable_out,
  output logic [`SRCR_FRAC_W-1:0]      feedback_fraction_out,
  output srcr_work_s                   work_settings_out
);

  // ***********************************************
  // Reset release and pin synchronisation
  // ***********************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic oe_pin_sync;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  srcr_sync2 u_oe_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_sync_ff),
    .d_in     (oe_pin_in),
    .q_out    (oe_pin_sync)
  );

  // ***********************************************
  // Address decode
  // ***********************************************
  function automatic logic is_ctrl(input logic [7:0] addr);
    is_ctrl = (addr == `SRCR_ADDR_CTRL_PRI) ||
              (addr == `SRCR_ADDR_CTRL_ALT);
  endfunction : is_ctrl

  function automatic logic [7:0] read_mux(input srcr_regs_s s,
                                          input logic [7:0] addr);
    if (is_ctrl(addr)) begin
      read_mux = {s.oe_override, `SRCR_CTRL_RSVD, s.cmd_cal, s.cmd_fine,
                  s.cmd_reload};
    end else if (addr == `SRCR_ADDR_FRAC_HI) begin
      read_mux = s.frac[`SRCR_FRAC_HI_BITS];
    end else if (addr == `SRCR_ADDR_FRAC_MID) begin
      read_mux = s.frac[`SRCR_FRAC_MID_BITS];
    end else if (addr == `SRCR_ADDR_FRAC_LO) begin
      read_mux = s.frac[`SRCR_FRAC_LO_BITS];
    end else begin
      read_mux = `SRCR_RD_UNMAP;
    end
  endfunction : read_mux

  // ***********************************************
  // State
  // ***********************************************
  srcr_regs_s regs_ff;
  srcr_regs_s nxt_regs;

  logic wr_ctrl;
  logic reload_want;

  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.nvm_req    = 1'b0;
    nxt_regs.cal_start  = 1'b0;
    nxt_regs.fine_start = 1'b0;
    wr_ctrl = reg_req_in.wr && is_ctrl(reg_req_in.addr);
    reload_want = regs_ff.cmd_reload || regs_ff.boot;

    if (reg_req_in.rd) begin
      nxt_regs.rdata = read_mux(regs_ff, reg_req_in.addr);
    end

    // Fraction byte writes
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        `SRCR_ADDR_FRAC_HI: begin
          nxt_regs.frac[`SRCR_FRAC_HI_BITS] = reg_req_in.wdata;
        end
        `SRCR_ADDR_FRAC_MID: begin
          nxt_regs.frac[`SRCR_FRAC_MID_BITS] = reg_req_in.wdata;
        end
        `SRCR_ADDR_FRAC_LO: begin
          nxt_regs.frac[`SRCR_FRAC_LO_BITS] = reg_req_in.wdata;
        end
        default: ;
      endcase
    end

    // Sequencer; completions clear command bits
    unique case (regs_ff.state)
      SRCR_IDLE: begin
        if (reload_want) begin
          nxt_regs.state   = SRCR_RELOAD;
          nxt_regs.nvm_req = 1'b1;
        end else if (regs_ff.cmd_cal) begin
          nxt_regs.state     = SRCR_CAL;
          nxt_regs.work      = {user_output_divider_ratio_in, user_integer_in,
                                regs_ff.frac};
          nxt_regs.cal_start = 1'b1;
        end else if (regs_ff.cmd_fine) begin
          nxt_regs.state      = SRCR_FINE;
          nxt_regs.work.feedback_integer  = user_integer_in;
          nxt_regs.work.frac  = regs_ff.frac;
          nxt_regs.fine_start = 1'b1;
        end
      end
      SRCR_RELOAD: begin
        if (nvm_done_in) begin
          // Store reload beats a same-cycle bus write to the bytes
          nxt_regs.frac = nvm_fraction_in;
          if (regs_ff.boot) begin
            // Power-up only: working copy follows the defaults
            nxt_regs.work.frac = nvm_fraction_in;
            nxt_regs.work.feedback_integer = user_integer_in;
            nxt_regs.work.output_divider_ratio = user_output_divider_ratio_in;
          end
          nxt_regs.boot       = 1'b0;
          nxt_regs.cmd_reload = 1'b0;
          nxt_regs.state      = SRCR_IDLE;
        end
      end
      SRCR_CAL: begin
        if (cal_done_in) begin
          // Calibration supersedes a pending small step
          nxt_regs.cmd_cal  = 1'b0;
          nxt_regs.cmd_fine = 1'b0;
          nxt_regs.state    = SRCR_IDLE;
        end
      end
      SRCR_FINE: begin
        if (fine_done_in) begin
          nxt_regs.cmd_fine = 1'b0;
          nxt_regs.state    = SRCR_IDLE;
        end
      end
    endcase

    // Control writes: bit 7 takes the written value; command bits: ones set, zeros ignored; set wins over clear
    if (wr_ctrl) begin
      nxt_regs.oe_override = reg_req_in.wdata[`SRCR_BIT_OE];
      if (reg_req_in.wdata[`SRCR_BIT_CAL]) begin
        nxt_regs.cmd_cal = 1'b1;
      end
      if (reg_req_in.wdata[`SRCR_BIT_FINE]) begin
        nxt_regs.cmd_fine = 1'b1;
      end
      if (reg_req_in.wdata[`SRCR_BIT_RELOAD]) begin
        nxt_regs.cmd_reload = 1'b1;
      end
    end

    // Open pin pulls to the enabling level for either polarity
    nxt_regs.oe_en = nxt_regs.oe_override ||
                     (oe_pin_sync ^ oe_active_low_in);
  end

  always_ff @(posedge clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      regs_ff.state       <= SRCR_IDLE;
      regs_ff.boot        <= 1'b1;
      regs_ff.oe_override <= `SRCR_RST_BIT;
      regs_ff.cmd_cal     <= `SRCR_RST_BIT;
      regs_ff.cmd_fine    <= `SRCR_RST_BIT;
      regs_ff.cmd_reload  <= `SRCR_RST_BIT;
      regs_ff.frac        <= `SRCR_RST_FRAC;
      regs_ff.work        <= {`SRCR_RST_OUTPUT_DIVIDER_RATIO, `SRCR_RST_INT,
                              `SRCR_RST_FRAC};
      regs_ff.rdata       <= `SRCR_RST_BYTE;
      regs_ff.oe_en       <= 1'b0;
      regs_ff.nvm_req     <= 1'b0;
      regs_ff.cal_start   <= 1'b0;
      regs_ff.fine_start  <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign reg_rdata_out         = regs_ff.rdata;
  assign nvm_reload_req_out    = regs_ff.nvm_req;
  assign cal_start_out         = regs_ff.cal_start;
  assign fine_start_out        = regs_ff.fine_start;
  assign clock_run_out         = (regs_ff.state != SRCR_CAL);
  assign output_enable_out     = regs_ff.oe_en;
  assign feedback_fraction_out = regs_ff.frac;
  assign work_settings_out     = regs_ff.work;

endmodule : synth_retune_control_regs

`default_nettype wire

// [verilog/srcr_regs.svh]
`ifndef SRCR_REGS_SVH
`define SRCR_REGS_SVH

// ***********************************************
// Register addresses
// ***********************************************
`define SRCR_ADDR_FRAC_HI  8'h12
`define SRCR_ADDR_FRAC_MID 8'h13
`define SRCR_ADDR_FRAC_LO  8'h14
`define SRCR_ADDR_CTRL_PRI 8'h15
`define SRCR_ADDR_CTRL_ALT 8'h50

// ***********************************************
// Control register fields
// ***********************************************
`define SRCR_BIT_OE     7
`define SRCR_BIT_CAL    2
`define SRCR_BIT_FINE   1
`define SRCR_BIT_RELOAD 0
`define SRCR_CTRL_RSVD  4'h0

// ***********************************************
// Fraction byte positions
// ***********************************************
`define SRCR_FRAC_HI_BITS  23:16
`define SRCR_FRAC_MID_BITS 15:8
`define SRCR_FRAC_LO_BITS  7:0

// ***********************************************
// Field widths and reset values
// ***********************************************
`define SRCR_FRAC_W     24
`define SRCR_INT_W      6
`define SRCR_OUTPUT_DIVIDER_RATIO_W     4
`define SRCR_RST_BIT    1'b0
`define SRCR_RST_BYTE   8'h00
`define SRCR_RST_FRAC   24'h000000
`define SRCR_RST_INT    6'h00
`define SRCR_RST_OUTPUT_DIVIDER_RATIO   4'h0
`define SRCR_RD_UNMAP   8'h00

`endif

// [verilog/srcr_pkg.sv]
`include "srcr_regs.svh"

package srcr_pkg;

  // Gray codes along idle -> reload -> calibrate, fine off idle
  typedef enum logic [1:0] {
    SRCR_IDLE   = 2'b00,
    SRCR_RELOAD = 2'b01,
    SRCR_CAL    = 2'b11,
    SRCR_FINE   = 2'b10
  } srcr_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srcr_reg_req_s;

  typedef struct packed {
    logic [`SRCR_OUTPUT_DIVIDER_RATIO_W-1:0] output_divider_ratio;
    logic [`SRCR_INT_W-1:0]  feedback_integer;
    logic [`SRCR_FRAC_W-1:0] frac;
  } srcr_work_s;

  typedef struct packed {
    srcr_state_e             state;
    logic                    boot;
    logic                    oe_override;
    logic                    cmd_cal;
    logic                    cmd_fine;
    logic                    cmd_reload;
    logic [`SRCR_FRAC_W-1:0] frac;
    srcr_work_s              work;
    logic [7:0]              rdata;
    logic                    oe_en;
    logic                    nvm_req;
    logic                    cal_start;
    logic                    fine_start;
  } srcr_regs_s;

endpackage : srcr_pkg

// [verilog/srcr_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; first stage feeds only the second
module srcr_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;

endmodule : srcr_sync2

`default_nettype wire

// [dv/srcr_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ******
// Port checker
// ******
module srcr_checker
  import srcr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       oe_pin_in,
  input wire logic       oe_active_low_in,
  input wire logic       cal_done_in,
  input wire logic       nvm_reload_req_out,
  input wire logic       cal_start_out,
  input wire logic       fine_start_out,
  input wire logic       clock_run_out,
  input wire logic       output_enable_out,
  input wire srcr_work_s work_settings_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence cal_hold_s; !clock_run_out && !cal_done_in; endsequence
  sequence cal_end_s; !clock_run_out && cal_done_in; endsequence
  cal_pulse_a: assert property (cal_start_out |=> !cal_start_out)
    else $error("Calibrate start too long");
  fine_pulse_a: assert property (fine_start_out |=> !fine_start_out)
    else $error("Fine start too long");
  reload_pulse_a: assert property (nvm_reload_req_out
    |=> !nvm_reload_req_out) else $error("Reload request too long");
  clock_stop_a: assert property ($fell(clock_run_out)
    |-> cal_start_out) else $error("Clock stopped without retune");
  cal_wait_a: assert property (cal_hold_s |=> !clock_run_out)
    else $error("Clock restarted before calibration end");
  cal_end_a: assert property (cal_end_s |=> clock_run_out)
    else $error("Clock not restarted");
  fine_run_a: assert property (fine_start_out |-> clock_run_out)
    else $error("Clock stopped in fine step");
  output_divider_ratio_keep_a: assert property (fine_start_out
    |-> $stable(work_settings_out.output_divider_ratio)) else $error("Divider moved");
  // Pin goes through a synchroniser, so a swap of pin and strap in one
  // cycle may dip the enable briefly; only a settled pair is judged
  pin_enable_a: assert property (((oe_pin_in ^ oe_active_low_in) &&
    $stable({oe_pin_in, oe_active_low_in}))[*6] |-> output_enable_out)
    else $error("Pin enable ignored");
endmodule : srcr_checker
bind synth_retune_control_regs srcr_checker chk_u (.clk_in, .rst_n_in,
  .oe_pin_in, .oe_active_low_in, .cal_done_in, .nvm_reload_req_out,
  .cal_start_out, .fine_start_out, .clock_run_out, .output_enable_out,
  .work_settings_out);
`default_nettype wire

// [dv/srcr_loop_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ******
// Loop and default store
// ******
module srcr_loop_model #(
  parameter logic [23:0] NVM_FRAC = 24'h5a5a5a
) (
  input  wire logic  clk_in,
  input  wire logic  nvm_req_in,
  input  wire logic  cal_start_in,
  input  wire logic  fine_start_in,
  input  wire logic [3:0] dly_in,
  output logic [2:0] done_out,
  output logic [23:0] nvm_fraction_out
);
  logic [2:0] kind_ff = 3'h0;
  logic [3:0] cnt_ff = 4'h0;
  logic [2:0] done_ff = 3'h0;
  // One job at a time; the block serialises its commands
  always @(posedge clk_in) begin
    done_ff <= 3'h0;
    if (|{nvm_req_in, cal_start_in, fine_start_in}) begin
      kind_ff <= {nvm_req_in, cal_start_in, fine_start_in};
      cnt_ff <= dly_in;
    end else if (kind_ff != 3'h0) begin
      if (cnt_ff == 4'h0) begin
        done_ff <= kind_ff;
        kind_ff <= 3'h0;
      end else cnt_ff <= cnt_ff - 4'h1;
    end
  end
  // Store lines carry junk outside the done cycle
  assign done_out = done_ff;
  assign nvm_fraction_out = done_ff[2] ? NVM_FRAC : ~NVM_FRAC;
endmodule : srcr_loop_model
`default_nettype wire

// [dv/synth_retune_control_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srcr_regs.svh"
module synth_retune_control_regs_test;
  import srcr_pkg::*;
  localparam logic [23:0] NVM = 24'h5a5a5a;
  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  srcr_reg_req_s req = '0;
  logic [7:0]    rdata, d;
  logic          pin = 1'b0, al = 1'b0, nvm_rq, cal_st, fine_st, run, oe;
  logic [2:0]    dn;
  logic [5:0]    uint = 6'h20;
  logic [3:0]    uodiv = 4'h3, dly = 4'h8;
  logic [23:0]   feedback_fraction, frac;
  srcr_work_s    work;
  int            fails = 0;
  int            n_checks = 0;
  always #50 clk_in = ~clk_in;
  synth_retune_control_regs dut_u (.clk_in, .rst_n_in, .reg_req_in(req),
    .reg_rdata_out(rdata), .oe_pin_in(pin), .oe_active_low_in(al),
    .user_integer_in(uint), .user_output_divider_ratio_in(uodiv), .nvm_fraction_in(feedback_fraction),
    .nvm_done_in(dn[2]), .cal_done_in(dn[1]), .fine_done_in(dn[0]),
    .nvm_reload_req_out(nvm_rq), .cal_start_out(cal_st),
    .fine_start_out(fine_st), .clock_run_out(run), .output_enable_out(oe),
    .feedback_fraction_out(frac), .work_settings_out(work));
  srcr_loop_model #(.NVM_FRAC(NVM)) far_u (.clk_in, .nvm_req_in(nvm_rq),
    .cal_start_in(cal_st), .fine_start_in(fine_st), .dly_in(dly),
    .done_out(dn), .nvm_fraction_out(feedback_fraction));
  task automatic chk(input logic [33:0] s, e, input string m);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_in) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk_in) req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req <= '0;
    @(posedge clk_in) #1 d = rdata;
  endtask : rd
  // Poll control until all command bits drop
  task automatic idle;
    for (int i = 0; i < 30; i++) begin
      rd(`SRCR_ADDR_CTRL_PRI);
      if (d[2:0] === 3'h0) return;
    end
    chk(1'b1, 1'b0, "command stuck");
  endtask : idle
  task automatic t_reset;
    // Power-up reload runs without a busy bit; let it finish first
    repeat (20) @(posedge clk_in);
    idle();
    chk(d, 8'h00, "ctrl reset");
    chk(frac, NVM, "fraction default");
    chk(work, {4'h3, 6'h20, NVM}, "power-up work");
    rd(8'h20);
    chk(d, `SRCR_RD_UNMAP, "unmapped read");
    wr(`SRCR_ADDR_FRAC_HI, 8'h12);
    wr(`SRCR_ADDR_FRAC_MID, 8'h34);
    wr(`SRCR_ADDR_FRAC_LO, 8'h56);
    chk(frac, 24'h123456, "fraction bytes");
    rd(`SRCR_ADDR_FRAC_MID);
    chk(d, 8'h34, "fraction read");
    $display("reset and fraction test done");
  endtask : t_reset
  task automatic t_oe;
    wr(`SRCR_ADDR_CTRL_PRI, 8'h80);
    rd(`SRCR_ADDR_CTRL_ALT);
    chk(d, 8'h80, "alias read");
    chk(oe, 1'b1, "override");
    wr(`SRCR_ADDR_CTRL_ALT, 8'h00);
    rd(`SRCR_ADDR_CTRL_PRI);
    chk(d, 8'h00, "alias clear");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) {al, pin} <= i[1:0];
      repeat (5) @(posedge clk_in);
      #1 chk(oe, pin ^ al, "pin enable");
    end
    $display("enable test done");
  endtask : t_oe
  task automatic t_retune;
    wr(`SRCR_ADDR_CTRL_PRI, 8'h04);
    repeat (3) @(posedge clk_in);
    #1 chk(run, 1'b0, "clock stopped");
    chk(work, {4'h3, 6'h20, 24'h123456}, "calibrated copy");
    rd(`SRCR_ADDR_CTRL_PRI);
    chk(d, 8'h04, "calibrate busy");
    idle();
    chk(run, 1'b1, "clock back");
    @(posedge clk_in) {uodiv, uint} <= {4'h9, 6'h12};
    wr(`SRCR_ADDR_FRAC_LO, 8'h78);
    wr(`SRCR_ADDR_CTRL_PRI, 8'h02);
    repeat (3) @(posedge clk_in);
    #1 chk(run, 1'b1, "clock runs");
    chk(work, {4'h3, 6'h12, 24'h123478}, "fine copy");
    rd(`SRCR_ADDR_CTRL_ALT);
    chk(d, 8'h02, "fine busy");
    idle();
    chk(d, 8'h00, "fine clear");
    $display("retune test done");
  endtask : t_retune
  task automatic t_reload;
    @(posedge clk_in) dly <= 4'h0;
    wr(`SRCR_ADDR_CTRL_PRI, 8'h01);
    idle();
    chk(frac, NVM, "reload fraction");
    chk(work, {4'h3, 6'h12, 24'h123478}, "work kept");
    @(posedge clk_in) dly <= 4'h5;
    wr(`SRCR_ADDR_FRAC_HI, 8'h00);
    wr(`SRCR_ADDR_CTRL_PRI, 8'h05);
    idle();
    chk(work, {4'h9, 6'h12, NVM}, "reload and retune");
    $display("reload test done");
  endtask : t_reload
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_oe();
    t_retune();
    t_reload();
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    fails++;
    $display("MISMATCH %0t watchdog", $time);
    complete_run();
  end
endmodule : synth_retune_control_regs_test
`default_nettype wire
